// [core/tlem_top.sv]
// Two-level event manager with an APB register slave and one interrupt request to the core.
//
// What this block does
// (RL1) Top pending and mask registers hold one bit per major event-raising module.
// (RL2) Modules with sub-functions get second-level pending and mask registers, bit each.
// (RL3) A top pending bit reaches the request only when its top mask bit is set.
// (RL4) A second-level event feeds its top bit only when its sub mask bit is set.
// (RL5) Writing one to the lowest-level pending bit clears it; zeros leave bits alone.
// (RL6) Modules without a second level, like the converter, pend in the top bit.
// (RL7) A module's top bit is the OR of its enabled second-level pending bits.
// (RL8) An event in the same cycle as its write-one clear leaves the bit set.
// (RL9) No counting; an enabled event recurring while still pending sets its miss bit.
// (RL10) Writing one to a miss bit clears it; zeros leave bits unchanged.
// (RL11) Events pending while globally disabled raise the request once enable returns.
// (RL12) Application mode writes to system top pending, mask and miss bits are ignored.
// (RL13) Application mode has full access to second-level pending and mask registers.
// (RL14) Any write to the software trigger register sets the software pending bit.
// (RL15) One global enable bit at position zero gates all requests; others read zero.
// (RL16) Top layout: watchdog 15 down to software 1; bit zero reads zero.
// (RL17) Source events are one-cycle pulses setting pending bits in that same cycle.
// (RL18) All pending sources merge into a single interrupt request line to the core.
// (RL19) Request is global enable AND the OR of pending AND mask over top bits.
//
// Chosen here: the APB interface to the registers.
`include "tlem_params.svh"

module tlem_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tlem_pkg::tlem_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor mode, high while application code runs.
  input wire logic app_mode,
  // One-cycle event pulses for modules that pend in the top word.
  input wire tlem_pkg::tlem_word_t direct_event,
  // One-cycle event pulses for modules with a second level.
  input wire tlem_pkg::tlem_sub_t timer_sub_event,
  input wire tlem_pkg::tlem_sub_t pins_sub_event,
  input wire tlem_pkg::tlem_sub_t serial_one_sub_event,
  input wire tlem_pkg::tlem_sub_t serial_two_sub_event,
  // Interrupt request to the core.
  output logic cpu_irq
);
  import tlem_pkg::*;

  // Address match against a register index.
  function automatic logic at_idx(input tlem_addr_t a, input logic [15:0] idx);
    at_idx = (a[17:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // Top-level bit that each second-level module drives.
  function automatic int sub_bit(input int g);
    case (g)
      0: sub_bit = `TLEM_BIT_TIMER;
      1: sub_bit = `TLEM_BIT_PINS;
      2: sub_bit = `TLEM_BIT_SER1;
      default: sub_bit = `TLEM_BIT_SER2;
    endcase
  endfunction

  // Registers and internal signals.
  tlem_word_t direct_pend_r;
  tlem_word_t top_mask_r;
  tlem_word_t miss_r;
  logic gate_r;
  logic [31:0] prdata_r;
  tlem_sub_t sub_evt [`TLEM_SUB_MODS];
  tlem_sub_t sub_pend_r [`TLEM_SUB_MODS];
  tlem_sub_t sub_mask_r [`TLEM_SUB_MODS];
  logic [`TLEM_SUB_MODS-1:0] sub_any;
  logic [`TLEM_SUB_MODS-1:0] sub_miss;
  logic [`TLEM_SUB_MODS-1:0] sub_p_hit;
  logic [`TLEM_SUB_MODS-1:0] sub_m_hit;
  tlem_word_t sub_vec;
  tlem_word_t sub_miss_vec;
  tlem_word_t top_pend;
  tlem_word_t wr_allow;
  tlem_word_t wdata16;
  logic wr_en;
  logic setup;
  logic access;
  logic mapped;

  // Bus phases; the slave never inserts wait states.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_en = access & pwrite;
  assign wdata16 = pwdata[15:0];
  assign pready = 1'b1;

  // System bits are write-protected while the core runs application code.
  assign wr_allow = app_mode ? `TLEM_APP_BITS : `TLEM_TOP_BITS; // [RL12]

  // Gather the second-level event ports into one array for the generate loop.
  assign sub_evt[0] = timer_sub_event;
  assign sub_evt[1] = pins_sub_event;
  assign sub_evt[2] = serial_one_sub_event;
  assign sub_evt[3] = serial_two_sub_event;

  // One second-level pending and mask pair per module with sub-functions.
  for (genvar g = 0; g < `TLEM_SUB_MODS; g++) begin : g_sub
    assign sub_p_hit[g] = at_idx(paddr, 16'(`TLEM_IDX_SUBP0 + g));
    assign sub_m_hit[g] = at_idx(paddr, 16'(`TLEM_IDX_SUBM0 + g));

    // Events set, write-one clears; the set term is ORed last so it wins.
    always_ff @(posedge clock or negedge nrst) begin // [RL2]
      if (!nrst) begin
        sub_pend_r[g] <= `TLEM_RST_SUB;
      end else begin
        sub_pend_r[g] <= (sub_pend_r[g] & ~((wr_en & sub_p_hit[g]) ? pwdata[7:0] : 8'h00)) // [RL5] [RL13]
                         | sub_evt[g]; // [RL8] [RL17]
      end
    end

    // Mask is fully writable in both modes.
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        sub_mask_r[g] <= `TLEM_RST_SUB;
      end else if (wr_en & sub_m_hit[g]) begin
        sub_mask_r[g] <= pwdata[7:0]; // [RL13]
      end
    end

    // Only enabled sub bits feed the module's top bit.
    assign sub_any[g] = |(sub_pend_r[g] & sub_mask_r[g]); // [RL4] [RL7]
    // An enabled sub event landing on an already pending bit is a miss.
    assign sub_miss[g] = |(sub_evt[g] & sub_pend_r[g] & sub_mask_r[g]); // [RL9]
  end

  // Place second-level summaries and misses at their top-level positions.
  always_comb begin
    sub_vec = `TLEM_RST_WORD;
    sub_miss_vec = `TLEM_RST_WORD;
    for (int g = 0; g < `TLEM_SUB_MODS; g++) begin
      sub_vec[sub_bit(g)] = sub_any[g]; // [RL7]
      sub_miss_vec[sub_bit(g)] = sub_miss[g];
    end
  end

  // Top pending word: direct bits from flops, second-level bits derived live.
  assign top_pend = (direct_pend_r & `TLEM_DIRECT_BITS) | sub_vec; // [RL1] [RL6] [RL16]

  // Direct pending bits; the software trigger always works, even for applications.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      direct_pend_r <= `TLEM_RST_WORD;
    end else begin
      direct_pend_r <= ((direct_pend_r
                         & ~((wr_en & at_idx(paddr, `TLEM_IDX_PEND)) ? (wdata16 & wr_allow) : `TLEM_RST_WORD)) // [RL5]
                        | (direct_event & `TLEM_DIRECT_BITS) // [RL6] [RL8] [RL17]
                        | ((wr_en & at_idx(paddr, `TLEM_IDX_SWTRIG)) ? 16'h0002 : `TLEM_RST_WORD)) // [RL14]
                       & `TLEM_DIRECT_BITS;
    end
  end

  // Miss bits record lost repeats; a new miss beats a same-cycle clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      miss_r <= `TLEM_RST_WORD;
    end else begin
      miss_r <= ((miss_r & ~((wr_en & at_idx(paddr, `TLEM_IDX_MISS)) ? (wdata16 & wr_allow) : `TLEM_RST_WORD)) // [RL10]
                 | (direct_event & direct_pend_r & top_mask_r & `TLEM_DIRECT_BITS) // [RL9]
                 | sub_miss_vec) & `TLEM_TOP_BITS;
    end
  end

  // Top mask; protected bits keep their value on application writes.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      top_mask_r <= `TLEM_RST_WORD;
    end else if (wr_en & at_idx(paddr, `TLEM_IDX_MASK)) begin
      top_mask_r <= (top_mask_r & ~wr_allow) | (wdata16 & wr_allow); // [RL12] [RL16]
    end
  end

  // Global enable; either mode may use it to fence short critical sections.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_r <= 1'b0;
    end else if (wr_en & at_idx(paddr, `TLEM_IDX_GATE)) begin
      gate_r <= pwdata[`TLEM_BIT_GATE]; // [RL15]
    end
  end

  // Single request line; pending bits survive a disabled gate and fire on re-enable.
  assign cpu_irq = gate_r & |(top_pend & top_mask_r); // [RL3] [RL11] [RL18] [RL19]

  // Decode of mapped indices, used by the error response only.
  always_comb begin
    mapped = at_idx(paddr, `TLEM_IDX_PEND) | at_idx(paddr, `TLEM_IDX_MISS)
             | at_idx(paddr, `TLEM_IDX_SWTRIG) | at_idx(paddr, `TLEM_IDX_GATE)
             | at_idx(paddr, `TLEM_IDX_MASK) | (|sub_p_hit) | (|sub_m_hit);
  end

  // Unmapped accesses answer with an error and change nothing.
  assign pslverr = access & ~mapped;

  // Read data is captured in the setup cycle so prdata comes from a flop.
  // The trade-off is that an event arriving in the setup cycle shows on the next read.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (at_idx(paddr, `TLEM_IDX_PEND)) begin
        prdata_r <= {16'h0000, top_pend};
      end
      if (at_idx(paddr, `TLEM_IDX_MISS)) begin
        prdata_r <= {16'h0000, miss_r};
      end
      if (at_idx(paddr, `TLEM_IDX_GATE)) begin
        prdata_r <= {31'h0000_0000, gate_r}; // [RL15]
      end
      if (at_idx(paddr, `TLEM_IDX_MASK)) begin
        prdata_r <= {16'h0000, top_mask_r & `TLEM_TOP_BITS}; // [RL16]
      end
      for (int g = 0; g < `TLEM_SUB_MODS; g++) begin
        if (sub_p_hit[g]) begin
          prdata_r <= {24'h00_0000, sub_pend_r[g]};
        end
        if (sub_m_hit[g]) begin
          prdata_r <= {24'h00_0000, sub_mask_r[g]};
        end
      end
    end
  end

  assign prdata = prdata_r;

endmodule

// [core/tlem_params.svh]
// Register indices, field masks, reset values and sizes of the two-level event manager.
`ifndef TLEM_PARAMS_SVH
`define TLEM_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define TLEM_IDX_PEND 16'h4600
`define TLEM_IDX_MISS 16'h4602
`define TLEM_IDX_SWTRIG 16'h4610
`define TLEM_IDX_GATE 16'h4618
`define TLEM_IDX_MASK 16'h461A
`define TLEM_IDX_SUBP0 16'h4620
`define TLEM_IDX_SUBM0 16'h4628

// Top-level bit positions.
`define TLEM_BIT_WDOG 15
`define TLEM_BIT_FAULT 14
`define TLEM_BIT_TIMER 13
`define TLEM_BIT_PINS 12
`define TLEM_BIT_CONV 11
`define TLEM_BIT_RX 10
`define TLEM_BIT_TX 9
`define TLEM_BIT_RTMR 8
`define TLEM_BIT_SEC 7
`define TLEM_BIT_SER2 6
`define TLEM_BIT_SER1 5
`define TLEM_BIT_SLEEP 4
`define TLEM_BIT_BB 3
`define TLEM_BIT_DBG 2
`define TLEM_BIT_SW 1
`define TLEM_BIT_GATE 0

// Field masks of the top-level word.
`define TLEM_TOP_BITS 16'hFFFE
`define TLEM_APP_BITS 16'h3860
`define TLEM_DIRECT_BITS 16'hCF9E

// Reset values.
`define TLEM_RST_WORD 16'h0000
`define TLEM_RST_SUB 8'h00

// Sizes.
`define TLEM_SUB_MODS 4
`define TLEM_SUB_W 8
`define TLEM_ADDR_W 18

`endif

// [core/tlem_pkg.sv]
// Types shared by the two-level event manager.
package tlem_pkg;
  typedef logic [15:0] tlem_word_t;
  typedef logic [7:0] tlem_sub_t;
  typedef logic [17:0] tlem_addr_t;
endpackage

// [sim/tlem_checker.sv]
// Port checker for the two-level event manager, bound to its top module.
`include "tlem_params.svh"
module tlem_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tlem_pkg::tlem_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Events and request.
  input wire tlem_pkg::tlem_word_t direct_event,
  input wire tlem_pkg::tlem_sub_t timer_sub_event,
  input wire tlem_pkg::tlem_sub_t pins_sub_event,
  input wire tlem_pkg::tlem_sub_t serial_one_sub_event,
  input wire tlem_pkg::tlem_sub_t serial_two_sub_event,
  input wire logic cpu_irq
);
  import tlem_pkg::*;
  logic gate_r;
  wire [15:0] idx = paddr[17:2];
  wire wr_acc = psel && penable && pwrite;
  wire any_ev = |{direct_event, timer_sub_event, pins_sub_event, serial_one_sub_event, serial_two_sub_event};
  // Shadow of the global enable, so the gate can be judged from the pins alone.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) gate_r <= 1'b0;
    else if (wr_acc && idx == `TLEM_IDX_GATE && paddr[1:0] == 2'h0) gate_r <= pwdata[0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Read setup edge of one register; the data appears in the access cycle.
  sequence rd_at(logic [15:0] a);
    psel && !penable && !pwrite && idx == a && paddr[1:0] == 2'h0;
  endsequence
  gate_off_a: assert property (!gate_r |-> !cpu_irq) else $error("irq while gate off");
  gate_read_a: assert property (rd_at(`TLEM_IDX_GATE) |=> prdata[31:1] == '0) else $error("gate bits");
  mask_read_a: assert property (rd_at(`TLEM_IDX_MASK) |=> prdata[0] == 1'b0 && prdata[31:16] == '0)
    else $error("mask bits");
  pend_read_a: assert property (rd_at(`TLEM_IDX_PEND) |=> prdata[0] == 1'b0 && prdata[31:16] == '0)
    else $error("pend bits");
  sub_read_a: assert property (rd_at(`TLEM_IDX_SUBP0) |=> prdata[31:8] == '0) else $error("sub bits");
  irq_cause_a: assert property ($rose(cpu_irq) |-> $past(wr_acc || any_ev)) else $error("irq no cause");
  irq_drop_a: assert property ($fell(cpu_irq) |-> $past(wr_acc)) else $error("irq fell unasked");
  rst_quiet_a: assert property (!$past(nrst) |-> !cpu_irq) else $error("irq after reset");
endmodule
bind tlem_top tlem_checker tlem_checker_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .direct_event(direct_event),
  .timer_sub_event(timer_sub_event), .pins_sub_event(pins_sub_event),
  .serial_one_sub_event(serial_one_sub_event), .serial_two_sub_event(serial_two_sub_event), .cpu_irq(cpu_irq));

// [sim/tlem_partner.sv]
// Event source model that sends one-cycle event pulses to the manager.
module tlem_partner (
  // Clock.
  input wire logic clock,
  // Event pulses.
  output tlem_pkg::tlem_word_t direct_event,
  output logic [31:0] sub_event
);
  timeunit 1ns;
  timeprecision 1ns;
  import tlem_pkg::*;
  initial begin
    direct_event = '0;
    sub_event = '0;
  end
  // Called just after an edge; the pulse is dropped at the next edge, so it is never wider.
  task automatic pulse(input logic [15:0] d, input logic [31:0] s);
    direct_event <= d;
    sub_event <= s;
    @(posedge clock);
    direct_event <= '0;
    sub_event <= '0;
  endtask
endmodule

// [sim/two_level_event_manager_tb.sv]
// Self-checking bench for the two-level event manager.
`include "tlem_params.svh"
module two_level_event_manager_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tlem_pkg::*;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, app_mode = 0, pready, pslverr, cpu_irq, se;
  tlem_addr_t paddr = '0;
  tlem_word_t dev;
  logic [31:0] pwdata = '0, prdata, rd, sev;
  int failures = 0, n_checks = 0, seed = 32'h99AA2744, k, rl[12];
  int pd, ms, mk, gt, sp[4], sm[4], sb[4] = '{13, 12, 5, 6};
  tlem_top tlem_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .app_mode(app_mode),
    .direct_event(dev), .timer_sub_event(sev[7:0]), .pins_sub_event(sev[15:8]),
    .serial_one_sub_event(sev[23:16]), .serial_two_sub_event(sev[31:24]), .cpu_irq(cpu_irq));
  tlem_partner tlem_partner_inst (.clock(clock), .direct_event(dev), .sub_event(sev));
  initial forever #20 clock = ~clock;
  // Model view of the top pending word; module bits are the OR of enabled sub bits.
  function automatic int topv();
    int t = pd;
    for (int j = 0; j < 4; j++) if (sp[j] & sm[j]) t |= 1 << sb[j];
    return t;
  endfunction
  function automatic int rdv(int a);
    case (a)
      `TLEM_IDX_PEND: return topv();
      `TLEM_IDX_MISS: return ms;
      `TLEM_IDX_GATE: return gt;
      `TLEM_IDX_MASK: return mk;
      default: return a < `TLEM_IDX_SUBM0 ? sp[a & 3] : sm[a & 3];
    endcase
  endfunction
  // Register writes; application mode keeps only the application bits of the top words.
  task automatic wr_m(int a, int w);
    int p = app_mode ? `TLEM_APP_BITS : 32'hFFFF;
    case (a)
      `TLEM_IDX_PEND: pd &= ~(w & p & `TLEM_DIRECT_BITS);
      `TLEM_IDX_MISS: ms &= ~(w & p & `TLEM_TOP_BITS);
      `TLEM_IDX_MASK: mk = (mk & ~p) | (w & p & `TLEM_TOP_BITS);
      `TLEM_IDX_GATE: gt = w & 1;
      `TLEM_IDX_SWTRIG: pd |= 2;
      default: if (a < `TLEM_IDX_SUBM0) sp[a & 3] &= ~(w & 32'hFF); else sm[a & 3] = w & 32'hFF;
    endcase
  endtask
  task automatic ev_m(int d, logic [31:0] s);
    d &= `TLEM_DIRECT_BITS;
    ms |= pd & d & mk;
    pd |= d;
    for (int j = 0; j < 4; j++) begin
      if (sp[j] & s[8*j +: 8] & sm[j]) ms |= 1 << sb[j];
      sp[j] |= s[8*j +: 8];
    end
  endtask
  task automatic chk(logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic look();
    @(negedge clock);
    chk(gt && (topv() & mk), cpu_irq);
    @(posedge clock);
  endtask
  // One APB transfer, optionally with a direct event pulse in its access cycle.
  task automatic apb(bit w, int a, logic [31:0] d, int e = 0);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a[15:0], 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    if (e) fork tlem_partner_inst.pulse(e, 0); join_none
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a != 16'h4601) wr_m(a, d);
    if (e) ev_m(e, 0);
    @(posedge clock);
  endtask
  task automatic ev(int d, logic [31:0] s);
    tlem_partner_inst.pulse(d, s);
    ev_m(d, s);
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end
  initial begin
    rl[0] = `TLEM_IDX_PEND;
    rl[1] = `TLEM_IDX_MISS;
    rl[2] = `TLEM_IDX_GATE;
    rl[3] = `TLEM_IDX_MASK;
    for (int j = 0; j < 4; j++) begin
      rl[4 + j] = `TLEM_IDX_SUBP0 + j;
      rl[8 + j] = `TLEM_IDX_SUBM0 + j;
    end
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    foreach (rl[j]) begin
      apb(0, rl[j], 0);
      chk(rdv(rl[j]), rd);
      chk(0, se);
    end
    apb(1, `TLEM_IDX_SWTRIG, 0);
    apb(1, `TLEM_IDX_MASK, 32'h2);
    look();
    apb(1, `TLEM_IDX_GATE, 32'h1);
    look();
    app_mode <= 1'b1;
    apb(1, `TLEM_IDX_PEND, 32'h2);
    look();
    app_mode <= 1'b0;
    ev(16'h0800, 0);
    apb(1, `TLEM_IDX_PEND, 32'h0800, 16'h0800);
    apb(0, `TLEM_IDX_PEND, 0);
    chk(rdv(`TLEM_IDX_PEND), rd);
    apb(1, 16'h4601, 32'hFFFF);
    chk(1, se);
    // Random mix of events, writes and reads in both processor modes.
    repeat (400) begin
      app_mode <= $random(seed);
      k = {$random(seed)} % 12;
      case ({$random(seed)} % 3)
        0: ev($random(seed), $random(seed) & $random(seed));
        1: apb(1, rl[k], $random(seed));
        default: begin
          apb(0, rl[k], 0);
          chk(rdv(rl[k]), rd);
        end
      endcase
      look();
    end
    give_verdict();
  end
endmodule
